// ### include/rrif_regs.vh
// constants for the radio rds interrupt flag block
`ifndef RRIF_REGS_VH
`define RRIF_REGS_VH
`define RRIF_CLK_HZ          100000000
`define RRIF_IF_DELAY_US     15000
`define RRIF_IF_DELAY_CYC    ((`RRIF_IF_DELAY_US * (`RRIF_CLK_HZ / 1000000)))
`define RRIF_LEV_PERIOD_US   500
`define RRIF_LEV_PERIOD_CYC  ((`RRIF_LEV_PERIOD_US * (`RRIF_CLK_HZ / 1000000)))
`define RRIF_PAUSE_CLR_US    500
`define RRIF_PAUSE_CLR_CYC   ((`RRIF_PAUSE_CLR_US * (`RRIF_CLK_HZ / 1000000)) + 1)
`define RRIF_PAUSE_HZ        2341
`define RRIF_PAUSE_CYC       (`RRIF_CLK_HZ / `RRIF_PAUSE_HZ)
`define RRIF_PAUSE_UP        16'h0001
`define RRIF_PAUSE_DOWN      16'h0008
`define RRIF_PAUSE_SCALE     16'h0925
`define RRIF_SSL_OFF         2'h3
`define RRIF_FLG_DAV         7
`define RRIF_FLG_LSYNC       5
`define RRIF_FLG_IF          4
`define RRIF_FLG_LEV         3
`define RRIF_FLG_PD          2
`define RRIF_FLG_FRR         1
`endif

// ### src/rrif_timer.v
// down counter that pulses on expiry, optionally reloading itself
`timescale 1ns/1ps
module rrif_timer #(
	parameter W      = 24,
	parameter RELOAD = 0
) (
	clk,
	rst_n,
	start,
	stop,
	load,
	running,
	done
);
	input  wire         clk;
	input  wire         rst_n;
	input  wire         start;
	input  wire         stop;
	input  wire [W-1:0] load;
	output reg          running;
	output reg          done;

	reg [W-1:0] cnt_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q   <= {W{1'b0}};
			running <= 1'b0;
			done    <= 1'b0;
		end else begin
			done <= 1'b0;
			if (stop) begin
				running <= 1'b0;
			end else if (start) begin
				cnt_q   <= load;
				running <= 1'b1;
			end else if (running) begin
				if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
					done <= 1'b1;
					if (RELOAD != 0) begin
						cnt_q <= load;
					end else begin
						running <= 1'b0;
					end
				end else begin
					cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule // rrif_timer

// ### src/rrif_flags.v
// interrupt flag logic of the fm/rds receiver
`timescale 1ns/1ps
`include "rrif_regs.vh"
module rrif_flags (
	clk,
	rst_n,
	rds_sync,
	rds_valid_block,
	rds_block_is_a,
	rds_pair_found,
	bad_block_count,
	bad_block_lose_limit,
	rds_sync_lost,
	standard_data_mode,
	fast_search_data_mode,
	reduced_data_mode,
	new_search_command,
	tune_start,
	tune_done,
	tune_done_is_af,
	tune_in_algo,
	if_count_bad,
	level_value,
	level_sample,
	search_stop_level,
	hysteresis_select,
	post_level_table,
	pause_below,
	pause_detector_power,
	pause_time_setting,
	mask_write,
	mask_wdata,
	read_flag_byte,
	read_last_block_low_byte,
	read_previous_block_low_byte,
	interrupt_mask_byte,
	flag_byte,
	sync_status,
	rds_idle,
	restart_search,
	sampled_pause_compare,
	interrupt_line_n
);
	input  wire        clk;
	input  wire        rst_n;
	input  wire        rds_sync;
	input  wire        rds_valid_block;
	input  wire        rds_block_is_a;
	input  wire        rds_pair_found;
	input  wire [5:0]  bad_block_count;
	input  wire [5:0]  bad_block_lose_limit;
	input  wire        rds_sync_lost;
	input  wire        standard_data_mode;
	input  wire        fast_search_data_mode;
	input  wire        reduced_data_mode;
	input  wire        new_search_command;
	input  wire        tune_start;
	input  wire        tune_done;
	input  wire        tune_done_is_af;
	input  wire        tune_in_algo;
	input  wire        if_count_bad;
	input  wire [3:0]  level_value;
	input  wire        level_sample;
	input  wire [1:0]  search_stop_level;
	input  wire        hysteresis_select;
	input  wire [31:0] post_level_table;
	input  wire        pause_below;
	input  wire        pause_detector_power;
	input  wire [7:0]  pause_time_setting;
	input  wire        mask_write;
	input  wire [7:0]  mask_wdata;
	input  wire        read_flag_byte;
	input  wire        read_last_block_low_byte;
	input  wire        read_previous_block_low_byte;
	output reg  [7:0]  interrupt_mask_byte;
	output reg  [7:0]  flag_byte;
	output reg         sync_status;
	output reg         rds_idle;
	output reg         restart_search;
	output reg         sampled_pause_compare;
	output reg         interrupt_line_n;

	// reset release and pin synchronisers
	reg       rst_m_q, rst_s_q;
	reg       pb_m_q, pb_s_q;
	wire      rst_i = rst_s_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_m_q <= 1'b0;
			rst_s_q <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_s_q <= rst_m_q;
		end
	end

	always @(posedge clk or negedge rst_i) begin
		if (!rst_i) begin
			pb_m_q <= 1'b0;
			pb_s_q <= 1'b0;
		end else begin
			pb_m_q <= pause_below;
			pb_s_q <= pb_m_q;
		end
	end

	// data available events
	reg  half_q;
	reg  dav_set;
	wire loss_auto = rds_sync_lost & ~interrupt_mask_byte[`RRIF_FLG_LSYNC];

	always @* begin
		dav_set = 1'b0;
		if (!rds_sync && !rds_idle) begin
			if (rds_pair_found && (bad_block_count < bad_block_lose_limit))
				dav_set = 1'b1;
			if (fast_search_data_mode && rds_valid_block && rds_block_is_a)
				dav_set = 1'b1;
		end else if (rds_sync && rds_valid_block) begin
			if (standard_data_mode || fast_search_data_mode)
				dav_set = 1'b1;
			else if (reduced_data_mode && half_q)
				dav_set = 1'b1;
		end
		if (rds_sync && loss_auto)
			dav_set = 1'b1;
	end

	always @(posedge clk or negedge rst_i) begin
		if (!rst_i) begin
			half_q <= 1'b0;
		end else if (!rds_sync || !reduced_data_mode) begin
			half_q <= 1'b0;
		end else if (rds_valid_block) begin
			half_q <= ~half_q;
		end
	end

	// tuning and pause timers: if counter delay, level period, pause clear window
	wire if_arm_pulse, lev_tick, pd_win_run;
	reg  post_algo_q;
	reg  [3:0] post_thr_q;
	localparam integer IF_DELAY_CYC   = `RRIF_IF_DELAY_CYC;
	localparam integer LEV_PERIOD_CYC = `RRIF_LEV_PERIOD_CYC;
	localparam integer PD_CLR_CYC     = `RRIF_PAUSE_CLR_CYC;
	localparam integer PD_RELOAD      = `RRIF_PAUSE_CYC - 1;

	rrif_timer #(.W(24), .RELOAD(0)) u_if_delay (
		.clk     (clk),
		.rst_n   (rst_i),
		.start   (tune_done),
		.stop    (tune_start),
		.load    (IF_DELAY_CYC[23:0]),
		.running (),
		.done    (if_arm_pulse)
	);
	reg  if_cont_q;

	rrif_timer #(.W(24), .RELOAD(1)) u_lev_tick (
		.clk     (clk),
		.rst_n   (rst_i),
		.start   (tune_done),
		.stop    (tune_start),
		.load    (LEV_PERIOD_CYC[23:0]),
		.running (),
		.done    (lev_tick)
	);

	wire [7:0] pt_ext = pause_time_setting;
	reg        pd_int_q;
	reg        pd_win_start;

	rrif_timer #(.W(24), .RELOAD(0)) u_pd_window (
		.clk     (clk),
		.rst_n   (rst_i),
		.start   (pd_win_start),
		.stop    (1'b0),
		.load    (PD_CLR_CYC[23:0]),
		.running (pd_win_run),
		.done    ()
	);

	// level threshold selection
	wire [3:0] ssl_thr = {search_stop_level, 2'b00};
	wire [3:0] hyst_thr = post_level_table[{search_stop_level, hysteresis_select, 2'b00} +: 4];
	wire       lev_low_algo = tune_in_algo && level_sample && (level_value < ssl_thr);
	wire       lev_low_post = post_algo_q && lev_tick && (level_value < post_thr_q);

	always @(posedge clk or negedge rst_i) begin
		if (!rst_i) begin
			post_algo_q <= 1'b0;
			post_thr_q  <= 4'h0;
			if_cont_q   <= 1'b0;
		end else begin
			if (tune_start) begin
				post_algo_q <= 1'b0;
				if_cont_q   <= 1'b0;
			end else if (tune_done) begin
				post_algo_q <= 1'b1;
				if (!tune_done_is_af && search_stop_level == `RRIF_SSL_OFF)
					post_thr_q <= 4'h0;
				else
					post_thr_q <= hyst_thr;
			end
			if (if_arm_pulse)
				if_cont_q <= 1'b1;
		end
	end

	// pause integrator
	reg  [15:0] pd_acc_q;
	reg  [15:0] pd_div_q;
	wire        pd_tick = (pd_div_q == 16'h0000);
	wire [23:0] pd_limit = pt_ext * `RRIF_PAUSE_SCALE;
	wire        pd_enable = pause_detector_power && !rds_idle;
	reg         pd_hit;

	always @(posedge clk or negedge rst_i) begin
		if (!rst_i) begin
			pd_div_q              <= 16'h0000;
			pd_acc_q              <= 16'h0000;
			sampled_pause_compare <= 1'b0;
			pd_hit                <= 1'b0;
		end else begin
			pd_hit   <= 1'b0;
			pd_div_q <= pd_tick ? PD_RELOAD[15:0] : pd_div_q - 16'h0001;
			if (!pd_enable) begin
				pd_acc_q <= 16'h0000;
			end else if (pd_tick) begin
				sampled_pause_compare <= pb_s_q;
				if ({8'h00, pd_acc_q} > pd_limit) begin
					pd_acc_q <= 16'h0000;
					pd_hit   <= 1'b1;
				end else if (pb_s_q) begin
					if (pd_acc_q != 16'hffff)
						pd_acc_q <= pd_acc_q + `RRIF_PAUSE_UP;
				end else if (pd_acc_q > `RRIF_PAUSE_DOWN) begin
					pd_acc_q <= pd_acc_q - `RRIF_PAUSE_DOWN;
				end else begin
					pd_acc_q <= 16'h0000;
				end
			end
		end
	end

	// flags, masks, sync state; set wins over clear
	wire ldav = dav_set;
	wire lsy  = rds_sync_lost & interrupt_mask_byte[`RRIF_FLG_LSYNC];
	wire lif  = (tune_in_algo & if_count_bad) | (if_cont_q & if_count_bad);
	wire lfrr = tune_done;
	wire llev = lev_low_algo | lev_low_post;
	wire lpd  = pd_hit & pd_enable;
	wire rd   = read_flag_byte;
	wire dav_clr = read_last_block_low_byte | read_previous_block_low_byte;
	wire pd_clr  = rd & ~pd_win_run & ~pd_int_q;
	wire [7:0] irq_vec = flag_byte & interrupt_mask_byte;

	always @(posedge clk or negedge rst_i) begin
		if (!rst_i) begin
			flag_byte           <= 8'h00;
			interrupt_mask_byte <= 8'h00;
			sync_status         <= 1'b0;
			rds_idle            <= 1'b0;
			restart_search      <= 1'b0;
			interrupt_line_n    <= 1'b1;
			pd_int_q            <= 1'b0;
			pd_win_start        <= 1'b0;
		end else begin
			sync_status    <= rds_sync & ~rds_sync_lost;
			restart_search <= loss_auto | (rds_idle & new_search_command);
			if (lsy)
				rds_idle <= 1'b1;
			else if (new_search_command)
				rds_idle <= 1'b0;
			if (mask_write)
				interrupt_mask_byte <= mask_wdata;
			if (ldav)
				flag_byte[`RRIF_FLG_DAV] <= 1'b1;
			else if (dav_clr)
				flag_byte[`RRIF_FLG_DAV] <= 1'b0;
			if (lsy)
				flag_byte[`RRIF_FLG_LSYNC] <= 1'b1;
			else if (rd)
				flag_byte[`RRIF_FLG_LSYNC] <= 1'b0;
			if (lif)
				flag_byte[`RRIF_FLG_IF] <= 1'b1;
			else if (rd || tune_start)
				flag_byte[`RRIF_FLG_IF] <= 1'b0;
			if (llev)
				flag_byte[`RRIF_FLG_LEV] <= 1'b1;
			else if (rd || tune_start)
				flag_byte[`RRIF_FLG_LEV] <= 1'b0;
			if (lfrr)
				flag_byte[`RRIF_FLG_FRR] <= 1'b1;
			else if (rd)
				flag_byte[`RRIF_FLG_FRR] <= 1'b0;
			if (lpd)
				flag_byte[`RRIF_FLG_PD] <= 1'b1;
			else if (pd_clr)
				flag_byte[`RRIF_FLG_PD] <= 1'b0;
			// window starts when the pause interrupt is raised
			pd_win_start <= lpd & interrupt_mask_byte[`RRIF_FLG_PD];
			pd_int_q     <= lpd & interrupt_mask_byte[`RRIF_FLG_PD];
			interrupt_line_n <= ~(|irq_vec);
		end
	end
endmodule // rrif_flags

// ### sim/rrif_flags_chk.sv
// assertion checker for the rds interrupt flag block
`timescale 1ns/1ps
module rrif_flags_chk (
	input wire       clk,
	input wire       rst_n,
	input wire       rds_sync,
	input wire       rds_valid_block,
	input wire       rds_pair_found,
	input wire       rds_sync_lost,
	input wire       standard_data_mode,
	input wire       tune_done,
	input wire       mask_write,
	input wire       read_flag_byte,
	input wire       read_last_block_low_byte,
	input wire [7:0] interrupt_mask_byte,
	input wire [7:0] flag_byte,
	input wire       sync_status,
	input wire       rds_idle,
	input wire       restart_search,
	input wire       interrupt_line_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_frr; tune_done |=> flag_byte[1]; endproperty
	property p_irq;
		tune_done && interrupt_mask_byte[1] && !flag_byte[1] && !mask_write
			|-> ##2 !interrupt_line_n;
	endproperty
	property p_quiet; ((flag_byte & interrupt_mask_byte) == 8'h00) [*3] |-> interrupt_line_n;
	endproperty
	property p_dav; rds_sync && standard_data_mode && rds_valid_block |=> flag_byte[7];
	endproperty
	property p_davclr;
		read_last_block_low_byte && !rds_valid_block && !rds_pair_found && !rds_sync_lost
			|=> !flag_byte[7];
	endproperty
	property p_sync; $rose(rds_sync) |-> ##[1:2] sync_status; endproperty
	property p_lost; rds_sync_lost && interrupt_mask_byte[5] |=> flag_byte[5] && rds_idle;
	endproperty
	property p_auto;
		rds_sync_lost && !interrupt_mask_byte[5] && !flag_byte[5]
			|-> ##1 !flag_byte[5] ##[0:1] restart_search;
	endproperty
	property p_keep; read_flag_byte && !mask_write |=> $stable(interrupt_mask_byte[5]);
	endproperty
	a_frr: assert property (p_frr) else $error("frr not set");
	a_irq: assert property (p_irq) else $error("no frr irq");
	a_quiet: assert property (p_quiet) else $error("irq unmasked");
	a_dav: assert property (p_dav) else $error("dav not set");
	a_davclr: assert property (p_davclr) else $error("dav not clr");
	a_sync: assert property (p_sync) else $error("sync stat");
	a_lost: assert property (p_lost) else $error("loss not flagged");
	a_auto: assert property (p_auto) else $error("auto restart");
	a_keep: assert property (p_keep) else $error("loss mask moved");
	c_frr: cover property (tune_done && interrupt_mask_byte[1]);
	c_lost: cover property (rds_sync_lost && interrupt_mask_byte[5]);
	c_dav: cover property (rds_valid_block && rds_sync);
	c_pd: cover property (flag_byte[2] && !rds_idle);
endmodule // rrif_flags_chk
bind rrif_flags rrif_flags_chk i_rrif_flags_chk (.clk, .rst_n, .rds_sync, .rds_valid_block,
	.rds_pair_found,
	.rds_sync_lost, .standard_data_mode, .tune_done, .mask_write, .read_flag_byte,
	.read_last_block_low_byte, .interrupt_mask_byte, .flag_byte, .sync_status, .rds_idle,
	.restart_search, .interrupt_line_n);

// ### sim/rrif_host.sv
// host model: byte reads and mask writes
`timescale 1ns/1ps
module rrif_host (
	input  wire        clk,
	output logic       rd_f,
	output logic       rd_l,
	output logic       rd_p,
	output logic       m_wr,
	output logic [7:0] m_wd
);
	initial begin
		{rd_p, rd_l, rd_f, m_wr} = 4'h0;
		m_wd = 8'h00;
	end
	// only host writes move the masks
	task automatic wr_mask(input logic [7:0] v);
		@(posedge clk);
		m_wr <= 1'b1;
		m_wd <= v;
		@(posedge clk);
		m_wr <= 1'b0;
		m_wd <= ~v;
		@(negedge clk);
	endtask
	// s = {prev, last, flag byte}
	task automatic rd(input logic [2:0] s);
		@(posedge clk);
		{rd_p, rd_l, rd_f} <= s;
		@(posedge clk);
		{rd_p, rd_l, rd_f} <= 3'h0;
		@(negedge clk);
	endtask
endmodule // rrif_host

// ### sim/rrif_flags_test.sv
// self-checking bench for the rds interrupt flag block
`timescale 1ns/1ps
module rrif_flags_test;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       rds_sync, rds_block_is_a, tune_in_algo, if_count_bad, tune_done_is_af;
	logic [6:0] ev; // lsample,tdone,tstart,nsearch,lost,pair,valid
	logic [2:0] mode;
	logic [5:0] bad_block_count, bad_block_lose_limit;
	logic [3:0] level_value;
	logic [1:0] search_stop_level;
	logic       hysteresis_select, pause_below, pause_detector_power;
	logic [31:0] post_level_table;
	logic [7:0] pause_time_setting;
	wire        rd_f, rd_l, rd_p, m_wr;
	wire  [7:0] m_wd, interrupt_mask_byte, flag_byte;
	wire        sync_status, rds_idle, interrupt_line_n, restart_search, sampled_pause_compare;
	int         n_mismatch = 0;
	int         n_checks = 0;
	always #5 clk = ~clk;
	rrif_host i_rrif_host (.clk, .rd_f, .rd_l, .rd_p, .m_wr, .m_wd);
	rrif_flags i_rrif_flags (.clk, .rst_n, .rds_sync, .rds_valid_block(ev[0]), .rds_block_is_a,
		.rds_pair_found(ev[1]), .bad_block_count, .bad_block_lose_limit,
		.rds_sync_lost(ev[2]), .standard_data_mode(mode[0]), .fast_search_data_mode(mode[1]),
		.reduced_data_mode(mode[2]), .new_search_command(ev[3]), .tune_start(ev[4]),
		.tune_done(ev[5]), .tune_done_is_af, .tune_in_algo, .if_count_bad, .level_value,
		.level_sample(ev[6]), .search_stop_level, .hysteresis_select, .post_level_table,
		.pause_below, .pause_detector_power, .pause_time_setting, .mask_write(m_wr),
		.mask_wdata(m_wd), .read_flag_byte(rd_f), .read_last_block_low_byte(rd_l),
		.read_previous_block_low_byte(rd_p), .interrupt_mask_byte, .flag_byte, .sync_status,
		.rds_idle, .restart_search, .sampled_pause_compare, .interrupt_line_n);
	task automatic chk(input string n, input logic [7:0] e, g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic pulse(input logic [6:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 7'h00;
		@(negedge clk);
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic t_tune;
		@(posedge clk);
		{tune_in_algo, if_count_bad} <= 2'h3;
		search_stop_level <= 2'h2;
		level_value <= 4'h8;
		pulse(7'h40);
		chk("if lev", 8'h02, flag_byte[4:3]);
		level_value <= 4'h7;
		pulse(7'h40);
		chk("if lev", 8'h03, flag_byte[4:3]);
		{tune_in_algo, if_count_bad} <= 2'h0;
		pulse(7'h10);
		chk("start clr", 8'h00, flag_byte[4:3]);
		i_rrif_host.wr_mask(8'h02);
		tune_done_is_af <= 1'b1;
		pulse(7'h20);
		chk("frr", 8'h01, flag_byte[1]);
		@(negedge clk);
		chk("line", 8'h00, interrupt_line_n);
		i_rrif_host.rd(3'h1);
		chk("frr clr", 8'h00, flag_byte[1]);
		i_rrif_host.wr_mask(8'h00);
	endtask
	task automatic t_modes;
		@(posedge clk);
		rds_sync <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			mode <= 3'h1 << i;
			i_rrif_host.rd(3'h2);
			pulse(7'h01);
			chk("dav 1", 8'(i != 2), flag_byte[7]);
			pulse(7'h01);
			chk("dav 2", 8'h01, flag_byte[7]);
			i_rrif_host.rd(3'h4);
			chk("dav clr", 8'h00, flag_byte[7]);
		end
		chk("sync", 8'h01, sync_status);
	endtask
	task automatic t_loss;
		i_rrif_host.wr_mask(8'h20);
		pulse(7'h04);
		chk("loss", 8'h01, flag_byte[5]);
		chk("idle", 8'h01, rds_idle);
		i_rrif_host.rd(3'h1);
		chk("loss clr", 8'h00, flag_byte[5]);
		chk("mask", 8'h20, interrupt_mask_byte);
		pulse(7'h08);
		chk("idle clr", 8'h00, rds_idle);
		chk("restart", 8'h01, restart_search);
		i_rrif_host.wr_mask(8'h00);
		i_rrif_host.rd(3'h2);
		pulse(7'h04);
		chk("auto dav", 8'h01, flag_byte[7]);
		chk("auto lf", 8'h00, flag_byte[5]);
		chk("auto ln", 8'h01, interrupt_line_n);
		chk("auto rs", 8'h01, restart_search);
	endtask
	task automatic t_search;
		@(posedge clk);
		rds_sync <= 1'b0;
		mode <= 3'h2;
		rds_block_is_a <= 1'b1;
		i_rrif_host.rd(3'h2);
		pulse(7'h01);
		chk("fast dav", 8'h01, flag_byte[7]);
		mode <= 3'h1;
		rds_block_is_a <= 1'b0;
		bad_block_count <= 6'h01;
		i_rrif_host.rd(3'h2);
		pulse(7'h02);
		chk("bbc lim", 8'h00, flag_byte[7]);
		bad_block_count <= 6'h00;
		pulse(7'h02);
		chk("pair dav", 8'h01, flag_byte[7]);
	endtask
	// hysteresis level tick and pause integrator; long waits
	task automatic t_slow;
		int w;
		@(posedge clk);
		hysteresis_select <= 1'b1;
		post_level_table <= 32'h0080_0000;
		level_value <= 4'h7;
		tune_done_is_af <= 1'b0;
		pause_detector_power <= 1'b1;
		pulse(7'h10);
		pulse(7'h20);
		i_rrif_host.rd(3'h1);
		repeat (49989) @(posedge clk);
		@(negedge clk);
		chk("lev early", 8'h00, flag_byte[3]);
		repeat (12) @(posedge clk);
		@(negedge clk);
		chk("lev post", 8'h01, flag_byte[3]);
		for (w = 0; w < 40000 && flag_byte[2] !== 1'b1; w++)
			@(posedge clk);
		@(negedge clk);
		chk("pause", 8'h01, flag_byte[2]);
		chk("pause cmp", 8'h01, sampled_pause_compare);
		i_rrif_host.rd(3'h1);
		chk("pause clr", 8'h00, flag_byte[2]);
	endtask
	initial begin
		{rds_sync, rds_block_is_a, tune_in_algo, if_count_bad, tune_done_is_af} = 5'h00;
		ev = 7'h00;
		mode = 3'h1;
		bad_block_count = 6'h00;
		bad_block_lose_limit = 6'h01;
		level_value = 4'hf;
		search_stop_level = 2'h0;
		{hysteresis_select, pause_detector_power, pause_below} = 3'h1;
		post_level_table = 32'h0000_0000;
		pause_time_setting = 8'h00;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk("flags", 8'h00, flag_byte);
		chk("masks", 8'h00, interrupt_mask_byte);
		chk("sync", 8'h00, sync_status);
		t_tune;
		t_modes;
		t_loss;
		t_search;
		t_slow;
		end_sim;
	end
	initial begin
		repeat (95000) @(posedge clk);
		n_mismatch++;
		end_sim;
	end
endmodule // rrif_flags_test
